// ==== rchc_pkg.sv ====
// Shared constants and types for the reset, clock and halt control block
package rchc_pkg;

   // Clock rates
   localparam int CLK_HZ  = 40_000_000;
   localparam int CLK_MHZ = CLK_HZ / 1_000_000;
   localparam int OSC_HZ  = 2_000_000;
   localparam int OSC_DIV = CLK_HZ / OSC_HZ;

   // Source edges per instruction tick for each clock source
   localparam int DIV_INT = 2;
   localparam int DIV_SQR = 1;
   localparam int DIV_EXT = 4;

   // Start-up delays in microseconds and in clock cycles
   localparam int WAKE_DLY_US  = 1000;
   localparam int RST_DLY_US   = 1000;
   localparam int WAKE_DLY_CYC = WAKE_DLY_US * CLK_MHZ;
   localparam int RST_DLY_CYC  = RST_DLY_US * CLK_MHZ;

   // Register bus
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] REG_PDC  = 4'h0;
   localparam logic [ADDR_W-1:0] REG_PMC  = 4'h1;
   localparam logic [ADDR_W-1:0] REG_INIT = 4'h2;
   localparam logic [ADDR_W-1:0] REG_STAT = 4'h3;

   // Field positions
   localparam int PDC_HALT_BIT = 0;
   localparam int STAT_WOKE_BIT = 4;
   localparam int STAT_STATE_LSB = 5;

   localparam logic [DATA_W-1:0] RD_ZERO = 8'h00;

   typedef enum logic [1:0] {
      CM_INT,
      CM_SQR,
      CM_XTAL,
      CM_RC
   } rchc_clock_source_select_t;

   typedef enum logic [2:0] {
      ST_HOLD,
      ST_START,
      ST_RUN,
      ST_HALT,
      ST_WAKE
   } rchc_state_t;

   typedef struct packed {
      rchc_clock_source_select_t clock_source_select;
      logic        brownout_enable_bit;
   } rchc_init_t;

   typedef struct packed {
      logic ext;
      logic wdt;
      logic bor;
      logic por;
   } rchc_src_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } rchc_bus_t;

   localparam rchc_init_t INIT_RST = '{clock_source_select: CM_INT, brownout_enable_bit: 1'b0};
   localparam rchc_src_t  SRC_NONE = '{ext: 1'b0, wdt: 1'b0, bor: 1'b0, por: 1'b0};

endpackage

// ==== rchc_clk_div.sv ====
// Oscillator model and instruction clock enable divider
`timescale 1ns/1ps

module rchc_clk_div
   import rchc_pkg::*;
#(
   parameter int OSC_CYC = OSC_DIV
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        osc_en,
   input  wire rchc_clock_source_select_t clk_sel,
   input  wire logic        cki_rise,
   output logic             tick_ff
);

   localparam int OW = $clog2(OSC_CYC + 1);

   generate
      if (OSC_CYC < 1) begin : g_chk
         $error("OSC_CYC must be at least one");
      end
   endgenerate

   logic [OW-1:0] osc_cnt_ff;
   logic          osc_tick_ff;
   logic [1:0]    edge_cnt_ff;
   logic [1:0]    edge_last;
   logic          src_pulse;

   // Internal 2 MHz oscillator, stopped when disabled
   always_ff @(posedge clk) begin
      if (!nrst || !osc_en) begin
         osc_cnt_ff  <= '0;
         osc_tick_ff <= 1'b0;
      end else if (osc_cnt_ff == OW'(OSC_CYC - 1)) begin
         osc_cnt_ff  <= '0;
         osc_tick_ff <= 1'b1;
      end else begin
         osc_cnt_ff  <= osc_cnt_ff + 1'b1;
         osc_tick_ff <= 1'b0;
      end
   end

   always_comb begin
      case (clk_sel)
         CM_INT:  begin src_pulse = osc_tick_ff; edge_last = 2'(DIV_INT - 1); end
         CM_SQR:  begin src_pulse = cki_rise;    edge_last = 2'(DIV_SQR - 1); end
         default: begin src_pulse = cki_rise;    edge_last = 2'(DIV_EXT - 1); end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         edge_cnt_ff <= '0;
         tick_ff     <= 1'b0;
      end else if (src_pulse && edge_cnt_ff >= edge_last) begin
         edge_cnt_ff <= '0;
         tick_ff     <= 1'b1;
      end else begin
         edge_cnt_ff <= src_pulse ? edge_cnt_ff + 1'b1 : edge_cnt_ff;
         tick_ff     <= 1'b0;
      end
   end

endmodule

// ==== rchc_top.sv ====
// Reset sequencer, clock source control and halt control
`timescale 1ns/1ps

// How it works
// - Brownout low holds reset; sequence starts after supply returns.
// - After the reset sequence the core is released to fetch and run.
// - Brownout acts only when enabled; enable is set only in programming mode.
// - Once enabled, brownout stays active every power-up; software cannot clear it.
// - Enable cleared only in programming mode with write protect off.
// - Any reset sequence returns I/O registers to reset, pins high-impedance.
// - System clock restarts only after the clock start-up delay.
// - Power-on, brownout, watchdog or external pin each start a reset.
// - Internal clock is the 2 MHz oscillator divided by two.
// - Oscillator runs after power-up except in halt or external clock.
// - Clock select: 00 internal, 01 square, 10 crystal, 11 RC.
// - Crystal and RC divided by four; square clock used undivided.
// - Writing one to halt bit enters halt; bit is write-only, self-clearing.
// - Halt stops oscillator, low battery and brownout detectors.
// - Only the multi-input wakeup or a power-on, watchdog or external reset leaves halt.
// - After wakeup a 1 ms start-up delay precedes execution.
module rchc_top
   import rchc_pkg::*;
#(
   parameter int RST_CYC  = RST_DLY_CYC,
   parameter int WAKE_CYC = WAKE_DLY_CYC
) (
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire rchc_bus_t         bus,
   output logic [DATA_W-1:0]      rdata_ff,
   input  wire logic              por_pin,
   input  wire logic              bod_low_pin,
   input  wire logic              ext_rst_n_pin,
   input  wire logic              wdt_rst,
   input  wire logic              prog_mode_pin,
   input  wire logic              global_write_protect,
   input  wire logic              prog_init_wr,
   input  wire rchc_init_t        prog_init_data,
   input  wire logic              multi_input_wakeup,
   input  wire logic              clock_input_pin,
   output logic                   core_rst_ff,
   output logic                   io_rst_ff,
   output logic                   core_run_ff,
   output logic                   instr_tick_ff,
   output logic                   osc_en_ff,
   output logic                   bod_en_ff,
   output logic                   lbd_en_ff,
   output logic                   halted_ff
);

   localparam int DLY_MAX = (RST_CYC > WAKE_CYC) ? RST_CYC : WAKE_CYC;
   localparam int DLY_W   = $clog2(DLY_MAX + 1);

   generate
      if (RST_CYC < 1 || WAKE_CYC < 1) begin : g_chk
         $error("Start-up delays must be at least one cycle");
      end
   endgenerate

   // Pin synchroniser lanes
   localparam int PIN_POR  = 0;
   localparam int PIN_BOD  = 1;
   localparam int PIN_EXT  = 2;
   localparam int PIN_PROG = 3;
   localparam int PIN_CKI  = 4;
   localparam int NPIN     = 5;

   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] s1_ff;
   logic [NPIN-1:0] s2_ff;
   logic [NPIN-1:0] s3_ff;
   logic [NPIN-1:0] pin_f_ff;
   logic            cki_d_ff;
   logic            cki_rise;
   logic            div_tick;

   rchc_state_t     state_ff;
   logic [DLY_W-1:0] dly_cnt_ff;
   rchc_init_t      init_ff;
   rchc_src_t       cause_ff;
   rchc_src_t       src;
   logic            woke_ff;
   logic            rst_req;
   logic            halt_wr;
   logic            pmc_wr;
   logic            stat_wr;
   logic            in_halt;

   assign pin_raw = {clock_input_pin, prog_mode_pin, ~ext_rst_n_pin, bod_low_pin, por_pin};

   // Three-stage synchronisers; value accepted when stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         always_ff @(posedge clk) begin
            if (!nrst) begin
               s1_ff[gi]    <= 1'b0;
               s2_ff[gi]    <= 1'b0;
               s3_ff[gi]    <= 1'b0;
               pin_f_ff[gi] <= 1'b0;
            end else begin
               s1_ff[gi] <= pin_raw[gi];
               s2_ff[gi] <= s1_ff[gi];
               s3_ff[gi] <= s2_ff[gi];
               if (s2_ff[gi] == s3_ff[gi]) begin
                  pin_f_ff[gi] <= s3_ff[gi];
               end
            end
         end
      end
   endgenerate

   assign in_halt = (state_ff == ST_HALT);

   always_comb begin
      src     = SRC_NONE;
      src.por = pin_f_ff[PIN_POR];
      // brownout only when enabled and awake
      src.bor = pin_f_ff[PIN_BOD] && init_ff.brownout_enable_bit && !in_halt;
      src.wdt = wdt_rst;
      src.ext = pin_f_ff[PIN_EXT];
   end

   assign rst_req = |src;

   assign halt_wr = bus.wr && bus.addr == REG_PDC && bus.wdata[PDC_HALT_BIT];
   assign pmc_wr  = bus.wr && bus.addr == REG_PMC;
   assign stat_wr = bus.wr && bus.addr == REG_STAT;

   // Reset, halt and start-up sequence
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_ff   <= ST_HOLD;
         dly_cnt_ff <= '0;
      end else if (rst_req) begin
         // held while any source is active
         state_ff   <= ST_HOLD;
         dly_cnt_ff <= '0;
      end else begin
         case (state_ff)
            ST_HOLD: begin
               state_ff   <= ST_START;
               dly_cnt_ff <= DLY_W'(RST_CYC - 1);
            end
            ST_START: begin
               if (dly_cnt_ff == '0) begin
                  state_ff <= ST_RUN;
               end else begin
                  dly_cnt_ff <= dly_cnt_ff - 1'b1;
               end
            end
            ST_RUN: begin
               if (halt_wr) begin
                  state_ff <= ST_HALT;
               end
            end
            ST_HALT: begin
               if (multi_input_wakeup) begin
                  state_ff   <= ST_WAKE;
                  dly_cnt_ff <= DLY_W'(WAKE_CYC - 1);
               end
            end
            ST_WAKE: begin
               if (dly_cnt_ff == '0) begin
                  state_ff <= ST_RUN;
               end else begin
                  dly_cnt_ff <= dly_cnt_ff - 1'b1;
               end
            end
            default: begin
               state_ff <= ST_HOLD;
            end
         endcase
      end
   end

   // Initialisation register, written only through the programming port
   always_ff @(posedge clk) begin
      if (!nrst) begin
         init_ff <= INIT_RST;
      end else if (prog_init_wr && pin_f_ff[PIN_PROG]) begin
         init_ff.clock_source_select <= prog_init_data.clock_source_select;
         // enable set only in programming mode
         if (prog_init_data.brownout_enable_bit) begin
            init_ff.brownout_enable_bit <= 1'b1;
         end else if (!global_write_protect) begin
            init_ff.brownout_enable_bit <= 1'b0;
         end
      end
   end

   // Sticky reset causes, cleared by writing ones; a new cause wins
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cause_ff <= SRC_NONE;
      end else begin
         cause_ff <= (cause_ff & ~(stat_wr ? bus.wdata[3:0] : 4'h0)) | src;
      end
   end

   // wake flag cleared by power mode clear write; wakeup wins
   always_ff @(posedge clk) begin
      if (!nrst) begin
         woke_ff <= 1'b0;
      end else if (in_halt && multi_input_wakeup) begin
         woke_ff <= 1'b1;
      end else if (pmc_wr) begin
         woke_ff <= 1'b0;
      end
   end

   // Register reads, data valid only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdata_ff <= RD_ZERO;
      end else if (bus.rd) begin
         case (bus.addr)
            // halt bit write-only, bit 1 zero
            REG_PDC:  rdata_ff <= RD_ZERO;
            REG_PMC:  rdata_ff <= RD_ZERO;
            REG_INIT: rdata_ff <= DATA_W'(init_ff);
            REG_STAT: rdata_ff <= {state_ff[2:0], woke_ff, cause_ff};
            default:  rdata_ff <= RD_ZERO;
         endcase
      end else begin
         rdata_ff <= RD_ZERO;
      end
   end

   // Synchronised clock input edge
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cki_d_ff <= 1'b0;
      end else begin
         cki_d_ff <= pin_f_ff[PIN_CKI];
      end
   end

   assign cki_rise = pin_f_ff[PIN_CKI] && !cki_d_ff;

   rchc_clk_div #(
      .OSC_CYC (OSC_DIV)
   ) u_div (
      .clk      (clk),
      .nrst     (nrst),
      .osc_en   (osc_en_ff),
      .clk_sel  (init_ff.clock_source_select),
      .cki_rise (cki_rise),
      .tick_ff  (div_tick)
   );

   // Sequence outputs
   always_ff @(posedge clk) begin
      if (!nrst) begin
         core_rst_ff   <= 1'b1;
         io_rst_ff     <= 1'b1;
         core_run_ff   <= 1'b0;
         instr_tick_ff <= 1'b0;
         halted_ff     <= 1'b0;
      end else begin
         io_rst_ff     <= rst_req || state_ff == ST_HOLD;
         core_rst_ff   <= rst_req || state_ff == ST_HOLD || state_ff == ST_START;
         core_run_ff   <= !rst_req && state_ff == ST_RUN;
         instr_tick_ff <= !rst_req && state_ff == ST_RUN && div_tick;
         halted_ff     <= in_halt;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         osc_en_ff <= 1'b1;
         bod_en_ff <= 1'b0;
         lbd_en_ff <= 1'b1;
      end else begin
         osc_en_ff <= !in_halt && init_ff.clock_source_select == CM_INT;
         bod_en_ff <= !in_halt && init_ff.brownout_enable_bit;
         lbd_en_ff <= !in_halt;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   property p_src_holds;
      (|src) |=> (core_rst_ff && io_rst_ff && !core_run_ff);
   endproperty
   a_src_holds: assert property (p_src_holds) else $error("Reset source did not hold reset");

   property p_bor_holds;
      (pin_f_ff[PIN_BOD] && init_ff.brownout_enable_bit && state_ff == ST_RUN) |=> ##1 (state_ff == ST_START || state_ff == ST_HOLD);
   endproperty
   a_bor_holds: assert property (p_bor_holds) else $error("Brownout did not reset");

   property p_release;
      (state_ff == ST_START && dly_cnt_ff == '0 && !rst_req) ##1 !rst_req |=> core_run_ff;
   endproperty
   a_release: assert property (p_release) else $error("Core not released after delay");

   property p_brownout_enable_bit_set;
      $rose(init_ff.brownout_enable_bit) |-> $past(pin_f_ff[PIN_PROG] && prog_init_wr);
   endproperty
   a_brownout_enable_bit_set: assert property (p_brownout_enable_bit_set) else $error("Brownout enable set outside programming");

   property p_brownout_enable_bit_sw;
      (bus.wr && bus.addr == REG_INIT && !prog_init_wr) |=> $stable(init_ff);
   endproperty
   a_brownout_enable_bit_sw: assert property (p_brownout_enable_bit_sw) else $error("Software changed init register");

   property p_brownout_enable_bit_clr;
      $fell(init_ff.brownout_enable_bit) |-> $past(pin_f_ff[PIN_PROG] && !global_write_protect);
   endproperty
   a_brownout_enable_bit_clr: assert property (p_brownout_enable_bit_clr) else $error("Brownout enable cleared illegally");

   property p_io_rst;
      io_rst_ff |-> core_rst_ff;
   endproperty
   a_io_rst: assert property (p_io_rst) else $error("I/O reset without core reset");

   property p_run_after_dly;
      $rose(core_run_ff) |-> $past(dly_cnt_ff, 2) == '0;
   endproperty
   a_run_after_dly: assert property (p_run_after_dly) else $error("Clock restarted before delay");

   property p_halt_entry;
      (state_ff == ST_RUN && halt_wr && !rst_req) |=> in_halt ##1 (halted_ff && !osc_en_ff);
   endproperty
   a_halt_entry: assert property (p_halt_entry) else $error("Halt not entered");

   property p_halt_off;
      halted_ff |-> (!osc_en_ff && !bod_en_ff && !lbd_en_ff && !core_run_ff);
   endproperty
   a_halt_off: assert property (p_halt_off) else $error("Subsystem running in halt");

   property p_halt_stay;
      (in_halt && !multi_input_wakeup && !rst_req) |=> in_halt;
   endproperty
   a_halt_stay: assert property (p_halt_stay) else $error("Halt left without wakeup");

   property p_wake_wait;
      (state_ff == ST_WAKE && dly_cnt_ff != '0 && !rst_req) |=> (state_ff == ST_WAKE && !core_run_ff);
   endproperty
   a_wake_wait: assert property (p_wake_wait) else $error("Execution resumed before wake delay");

   property p_pdc_read;
      (bus.rd && bus.addr == REG_PDC) |=> rdata_ff == RD_ZERO;
   endproperty
   a_pdc_read: assert property (p_pdc_read) else $error("Power-down register read not zero");

endmodule

// ==== rchc_top_tb.sv ====
// Self-checking testbench for the reset, clock and halt control block
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; $display("[ERR] t=%0t got %0h exp %0h", $time, (got), (exp)); end end

module rchc_top_tb
   import rchc_pkg::*;
;
   localparam int RST_N    = 8;
   localparam int WAKE_N   = 10;
   localparam int CKI_HALF = 3;

   logic              clk = 1'b0;
   logic              nrst = 1'b0;
   rchc_bus_t         bus = '0;
   logic [DATA_W-1:0] rdata_ff;
   logic              por_pin = 1'b0;
   logic              bod_low_pin = 1'b0;
   logic              ext_rst_n_pin = 1'b1;
   logic              wdt_rst = 1'b0;
   logic              prog_mode_pin = 1'b0;
   logic              global_write_protect = 1'b0;
   logic              prog_init_wr = 1'b0;
   rchc_init_t        prog_init_data = INIT_RST;
   logic              multi_input_wakeup = 1'b0;
   logic              clock_input_pin = 1'b0;
   logic              core_rst_ff;
   logic              io_rst_ff;
   logic              core_run_ff;
   logic              instr_tick_ff;
   logic              osc_en_ff;
   logic              bod_en_ff;
   logic              lbd_en_ff;
   logic              halted_ff;
   int                error_cnt = 0;
   int                comparisons = 0;
   int                seed = 95;
   int                n;
   int                cki_cnt = 0;
   logic [7:0]        d;

   rchc_top #(.RST_CYC(RST_N), .WAKE_CYC(WAKE_N)) u_rchc_top (
      .clk                  (clk),
      .nrst                 (nrst),
      .bus                  (bus),
      .rdata_ff             (rdata_ff),
      .por_pin              (por_pin),
      .bod_low_pin          (bod_low_pin),
      .ext_rst_n_pin        (ext_rst_n_pin),
      .wdt_rst              (wdt_rst),
      .prog_mode_pin        (prog_mode_pin),
      .global_write_protect (global_write_protect),
      .prog_init_wr         (prog_init_wr),
      .prog_init_data       (prog_init_data),
      .multi_input_wakeup   (multi_input_wakeup),
      .clock_input_pin      (clock_input_pin),
      .core_rst_ff          (core_rst_ff),
      .io_rst_ff            (io_rst_ff),
      .core_run_ff          (core_run_ff),
      .instr_tick_ff        (instr_tick_ff),
      .osc_en_ff            (osc_en_ff),
      .bod_en_ff            (bod_en_ff),
      .lbd_en_ff            (lbd_en_ff),
      .halted_ff            (halted_ff)
   );

   always #12.5 clk = ~clk;

   // External clock source
   always @(posedge clk) begin
      if (cki_cnt == CKI_HALF - 1) begin
         cki_cnt <= 0;
         clock_input_pin <= ~clock_input_pin;
      end else begin
         cki_cnt <= cki_cnt + 1;
      end
   end

   task automatic print_verdict();
      $display("Comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   function automatic int tick_gap(input logic [1:0] cm);
      case (cm)
         2'b00: return OSC_DIV * DIV_INT;
         2'b01: return 2 * CKI_HALF * DIV_SQR;
         default: return 2 * CKI_HALF * DIV_EXT;
      endcase
   endfunction

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask

   task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
      @(posedge clk);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [7:0] v);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      @(negedge clk);
      v = rdata_ff;
   endtask

   // Waits on a chosen output level, counting falling edges
   task automatic wait_on(input int w, input logic lvl, output int k);
      logic s;
      k = 0;
      forever begin
         @(negedge clk);
         case (w)
            0: s = core_run_ff;
            1: s = core_rst_ff;
            2: s = instr_tick_ff;
            default: s = halted_ff;
         endcase
         if (s === lvl || k >= 5000) break;
         k++;
      end
      if (k >= 5000) begin
         error_cnt++;
         $display("[ERR] t=%0t wait timeout", $time);
         print_verdict();
      end
      @(posedge clk);
   endtask

   task automatic prog_write(input logic [1:0] cm, input logic be, input logic wp);
      @(posedge clk);
      prog_mode_pin <= 1'b1;
      global_write_protect <= wp;
      cyc(6);
      prog_init_wr <= 1'b1;
      prog_init_data <= '{clock_source_select: rchc_clock_source_select_t'(cm), brownout_enable_bit: be};
      cyc(1);
      prog_init_wr <= 1'b0;
      prog_mode_pin <= 1'b0;
      cyc(6);
   endtask

   task automatic set_src(input int s, input logic v);
      case (s)
         0: por_pin <= v;
         1: bod_low_pin <= v;
         2: wdt_rst <= v;
         default: ext_rst_n_pin <= ~v;
      endcase
   endtask

   task automatic src_reset(input int s);
      int h;
      h = 3 + ($random(seed) & 7);
      @(posedge clk);
      set_src(s, 1'b1);
      wait_on(1, 1'b1, n);
      `CHK(n <= 8, 1'b1)
      cyc(h);
      @(negedge clk);
      `CHK({core_rst_ff, io_rst_ff, core_run_ff}, 3'b110)
      @(posedge clk);
      set_src(s, 1'b0);
      wait_on(0, 1'b1, n);
      `CHK((n >= RST_N) && (n <= RST_N + 10), 1'b1)
      bus_rd(REG_STAT, d);
      `CHK({d[7:5], d[s]}, 4'b0101)
      bus_wr(REG_STAT, 8'h01 << s);
      bus_rd(REG_STAT, d);
      `CHK(d[s], 1'b0)
      $display("Source %0d reset test done", s);
   endtask

   initial begin
      cyc(5);
      @(negedge clk);
      `CHK({core_rst_ff, io_rst_ff, core_run_ff, instr_tick_ff}, 4'b1100)
      `CHK({osc_en_ff, bod_en_ff, lbd_en_ff, halted_ff, rdata_ff}, 12'ha00)
      @(posedge clk);
      nrst <= 1'b1;
      wait_on(0, 1'b1, n);
      `CHK((n >= RST_N) && (n <= RST_N + 4), 1'b1)
      bus_rd(REG_PDC, d);
      `CHK(d[1:0], 2'b00)
      bus_wr(4'hf, 8'($random(seed)));
      bus_rd(4'hf, d);
      `CHK(d, RD_ZERO)
      $display("Reset test done");

      for (int m = 0; m < 4; m++) begin
         prog_write(m[1:0], 1'b0, 1'b0);
         bus_rd(REG_INIT, d);
         `CHK(d, {5'h00, m[1:0], 1'b0})
         wait_on(2, 1'b1, n);
         wait_on(2, 1'b1, n);
         `CHK(n + 1, tick_gap(m[1:0]))
         @(negedge clk);
         `CHK(osc_en_ff, (m == 0))
      end
      $display("Clock source test done");

      @(posedge clk);
      bod_low_pin <= 1'b1;
      cyc(10);
      @(negedge clk);
      `CHK(core_rst_ff, 1'b0)
      @(posedge clk);
      bod_low_pin <= 1'b0;
      prog_init_wr <= 1'b1;
      prog_init_data <= '{clock_source_select: CM_INT, brownout_enable_bit: 1'b1};
      @(posedge clk);
      prog_init_wr <= 1'b0;
      bus_rd(REG_INIT, d);
      `CHK(d, {5'h00, CM_RC, 1'b0})
      prog_write(2'b00, 1'b1, 1'b1);
      @(negedge clk);
      `CHK(bod_en_ff, 1'b1)
      bus_wr(REG_INIT, 8'h00);
      bus_rd(REG_INIT, d);
      `CHK(d, 8'h01)
      prog_write(2'b00, 1'b0, 1'b1);
      bus_rd(REG_INIT, d);
      `CHK(d, 8'h01)
      $display("Brownout enable test done");

      for (int s = 0; s < 4; s++) src_reset(s);

      bus_wr(REG_PDC, 8'h01);
      wait_on(3, 1'b1, n);
      `CHK(n <= 3, 1'b1)
      @(negedge clk);
      `CHK({osc_en_ff, bod_en_ff, lbd_en_ff, core_run_ff}, 4'h0)
      bus_rd(REG_PDC, d);
      `CHK(d[1:0], 2'b00)
      @(posedge clk);
      bod_low_pin <= 1'b1;
      cyc(4 + ($random(seed) & 15));
      @(negedge clk);
      `CHK({halted_ff, core_rst_ff}, 2'b10)
      @(posedge clk);
      bod_low_pin <= 1'b0;
      cyc(8);
      multi_input_wakeup <= 1'b1;
      @(posedge clk);
      multi_input_wakeup <= 1'b0;
      wait_on(0, 1'b1, n);
      `CHK((n >= WAKE_N) && (n <= WAKE_N + 3), 1'b1)
      @(negedge clk);
      `CHK({halted_ff, osc_en_ff, bod_en_ff}, 3'b011)
      bus_rd(REG_STAT, d);
      `CHK(d[STAT_WOKE_BIT], 1'b1)
      // Clear power mode after wakeup
      bus_wr(REG_PMC, 8'($random(seed)));
      bus_rd(REG_STAT, d);
      `CHK(d[STAT_WOKE_BIT], 1'b0)
      $display("Halt test done");

      prog_write(2'b00, 1'b0, 1'b0);
      bus_rd(REG_INIT, d);
      `CHK(d, 8'h00)
      $display("Brownout clear test done");
      print_verdict();
   end
endmodule
